/* inc/smiu_consts.svh */
// Purpose: Constants of the status-mode interrupt unit
// Assumes: Included by the package, by the top module and by the testbench
// Notes: Definitions only
`ifndef SMIU_CONSTS_SVH
`define SMIU_CONSTS_SVH

// Widths
`define SMIU_AW 4
`define SMIU_DW 16
`define SMIU_NLINE 16
`define SMIU_IW 4
`define SMIU_NPIN 33
`define SMIU_DIV_W 20
`define SMIU_IO_W 8
`define SMIU_MW 19

// Register offsets
`define SMIU_A_SM_MICRO 4'h0
`define SMIU_A_SM_MACRO 4'h1
`define SMIU_A_MASK_MICRO 4'h2
`define SMIU_A_MASK_MACRO 4'h3
`define SMIU_A_PEND_MICRO 4'h4
`define SMIU_A_PEND_MACRO 4'h5
`define SMIU_A_LIMIT 4'h6
`define SMIU_A_CLK_CTRL 4'h7
`define SMIU_A_VECTOR 4'h8
`define SMIU_A_PARITY 4'h9

// Reset values
`define SMIU_RST_WORD 16'h0000
`define SMIU_RST_LIMIT 16'h0001

// Status-mode bit positions
`define SMIU_B_TWOS 0
`define SMIU_B_MACRO_EN 0
`define SMIU_IO_LSB 8

// Interrupt line positions
`define SMIU_L_RTC 8
`define SMIU_L_PARITY 0

// Clock control bits (write: commands, read: status)
`define SMIU_C_LIM_EN 0
`define SMIU_C_LIM_DIS 1
`define SMIU_C_EVERY 2
`define SMIU_C_CLR_LIM 3
`define SMIU_C_CLR_LOST 4
`define SMIU_S_LIM_FLAG 5
`define SMIU_S_LOST 6

// Parity status bits
`define SMIU_P_ERR 0
`define SMIU_P_WORD 1
`define SMIU_P_PROT 2

// Memory word layout
`define SMIU_M_DPAR 16
`define SMIU_M_PROT 17
`define SMIU_M_PPAR 18
`define SMIU_PAR_ODD 1'b1

// Pin vector layout
`define SMIU_P_MICRO_LSB 0
`define SMIU_P_MACRO_LSB 16
`define SMIU_P_PROT_SW 32

// Real-time clock timing
`define SMIU_RTC_PER_NS 3300000
`define SMIU_CLK_NS 10

`endif

/* inc/smiu_pkg.sv */
// Purpose: Types of the status-mode interrupt unit
// Assumes: Header of constants is on the include path
// Notes: State of the top module is one packed struct
`include "smiu_consts.svh"

package smiu_pkg;

  typedef struct packed {
    logic [`SMIU_NPIN-1:0] s1;
    logic [`SMIU_NPIN-1:0] s2;
    logic [`SMIU_NPIN-1:0] s3;
    logic [`SMIU_NPIN-1:0] lvl;
    logic [`SMIU_DW-1:0] sm_micro;
    logic [`SMIU_DW-1:0] sm_macro;
    logic [`SMIU_DW-1:0] mask_micro;
    logic [`SMIU_DW-1:0] mask_macro;
    logic [`SMIU_NLINE-1:0] pend_micro;
    logic [`SMIU_NLINE-1:0] pend_macro;
    logic [`SMIU_DW-1:0] limit_n;
    logic [`SMIU_DW-1:0] tick_cnt;
    logic [`SMIU_DIV_W-1:0] div_cnt;
    logic lim_en;
    logic every_tick;
    logic lim_flag;
    logic lost_cnt;
    logic par_err;
    logic par_word;
    logic par_prot;
    logic rtc_tick;
    logic serv_valid;
    logic serv_micro;
    logic [`SMIU_IW-1:0] serv_index;
    logic [`SMIU_DW-1:0] rdata;
  } smiu_state_t;

endpackage

/* src/smiu_prio_enc.sv */
// Purpose: Priority encoder over masked interrupt lines
// Assumes: Line 0 has the highest priority
// Notes: Purely combinational
`timescale 1ns/100ps

module smiu_prio_enc #(
  parameter int N = 16,
  parameter int IW = 4
) (
  input wire logic [N-1:0] req,
  input wire logic [N-1:0] mask,
  output logic valid,
  output logic [IW-1:0] index
);

  logic [N-1:0] act;

  always_comb
  begin
    act = req & mask;
    valid = |act;
    index = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (act[i])
      begin
        index = IW'(i);
      end
    end
  end

endmodule

/* src/smiu_top.sv */
// Purpose: Status-mode registers, interrupt holding, masking and priority
// Assumes: One clock, asynchronous active-low master clear
// Notes: Request and switch pins pass a three-stage filter
`timescale 1ns/100ps
`include "smiu_consts.svh"

module smiu_top #(
  parameter int TICK_CYCLES = `SMIU_RTC_PER_NS / `SMIU_CLK_NS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [`SMIU_AW-1:0] addr,
  input wire logic [`SMIU_DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [`SMIU_DW-1:0] rdata,
  input wire logic [`SMIU_NLINE-1:0] micro_req,
  input wire logic [`SMIU_NLINE-1:0] macro_req,
  input wire logic protect_sw,
  input wire logic [`SMIU_DW-1:0] alu_result,
  input wire logic alu_ld_sm_micro,
  input wire logic alu_ld_sm_macro,
  input wire logic alu_ld_mask_micro,
  input wire logic alu_ld_mask_macro,
  input wire logic mem_chk,
  input wire logic [`SMIU_MW-1:0] mem_word,
  output logic serv_valid,
  output logic serv_micro,
  output logic [`SMIU_IW-1:0] serv_index,
  output logic twos_comp,
  output logic macro_int_en,
  output logic [`SMIU_IO_W-1:0] io_timing,
  output logic rtc_tick,
  output logic limit_flag,
  output logic lost_count,
  output logic parity_err
);

  localparam int DIVW = `SMIU_DIV_W;
  localparam logic [DIVW-1:0] TICK_M1 = DIVW'(TICK_CYCLES - 1);

  smiu_pkg::smiu_state_t st_reg;
  smiu_pkg::smiu_state_t st_next;

  logic [`SMIU_NPIN-1:0] pins;
  logic [`SMIU_NPIN-1:0] agree;
  logic [`SMIU_NLINE-1:0] micro_lvl;
  logic [`SMIU_NLINE-1:0] macro_lvl;
  logic [`SMIU_NLINE-1:0] micro_set;
  logic [`SMIU_NLINE-1:0] macro_set;
  logic [`SMIU_NLINE-1:0] micro_clr;
  logic [`SMIU_NLINE-1:0] macro_clr;
  logic [`SMIU_DW-1:0] tick_inc;
  logic tick;
  logic lim_evt;
  logic word_bad;
  logic prot_bad;
  logic prot_on;
  logic mi_valid;
  logic ma_valid;
  logic [`SMIU_IW-1:0] mi_index;
  logic [`SMIU_IW-1:0] ma_index;

  // Write select for one register
  function automatic logic wsel(input logic [`SMIU_AW-1:0] a);
    wsel = wr && (addr == a);
  endfunction

  assign pins = {protect_sw, macro_req, micro_req};

  // Micro group encoder
  smiu_prio_enc #(
    .N(`SMIU_NLINE),
    .IW(`SMIU_IW)
  ) u_enc_micro (
    .req(st_reg.pend_micro),
    .mask(st_reg.mask_micro),
    .valid(mi_valid),
    .index(mi_index)
  );

  // Macro group encoder
  smiu_prio_enc #(
    .N(`SMIU_NLINE),
    .IW(`SMIU_IW)
  ) u_enc_macro (
    .req(st_reg.pend_macro),
    .mask(st_reg.mask_macro),
    .valid(ma_valid),
    .index(ma_index)
  );

  always_comb
  begin
    st_next = st_reg;

    // Three-stage pin filter
    st_next.s1 = pins;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    agree = ~(st_reg.s2 ^ st_reg.s3);
    st_next.lvl = (agree & st_reg.s3) | (~agree & st_reg.lvl);
    micro_lvl = st_reg.lvl[`SMIU_P_MICRO_LSB +: `SMIU_NLINE];
    macro_lvl = st_reg.lvl[`SMIU_P_MACRO_LSB +: `SMIU_NLINE];
    prot_on = st_reg.lvl[`SMIU_P_PROT_SW];

    // Status-mode, mask and limit registers from the bus
    if (wsel(`SMIU_A_SM_MICRO))
    begin
      st_next.sm_micro = wdata;
    end
    if (wsel(`SMIU_A_SM_MACRO))
    begin
      st_next.sm_macro = wdata;
    end
    if (wsel(`SMIU_A_MASK_MICRO))
    begin
      st_next.mask_micro = wdata;
    end
    if (wsel(`SMIU_A_MASK_MACRO))
    begin
      st_next.mask_macro = wdata;
    end
    if (wsel(`SMIU_A_LIMIT))
    begin
      st_next.limit_n = wdata;
    end

    // ALU result loads take precedence over the bus
    if (alu_ld_sm_micro)
    begin
      st_next.sm_micro = alu_result;
    end
    if (alu_ld_sm_macro)
    begin
      st_next.sm_macro = alu_result;
    end
    if (alu_ld_mask_micro)
    begin
      st_next.mask_micro = alu_result;
    end
    if (alu_ld_mask_macro)
    begin
      st_next.mask_macro = alu_result;
    end

    // Clock divider for the periodic tick
    tick = (st_reg.div_cnt == TICK_M1);
    if (tick)
    begin
      st_next.div_cnt = '0;
    end
    else
    begin
      st_next.div_cnt = st_reg.div_cnt + DIVW'(1);
    end
    st_next.rtc_tick = tick;

    // Count of ticks up to the limit
    lim_evt = 1'b0;
    tick_inc = st_reg.tick_cnt + `SMIU_RST_LIMIT;
    if (tick)
    begin
      if (st_reg.every_tick || (tick_inc >= st_reg.limit_n))
      begin
        lim_evt = 1'b1;
        st_next.tick_cnt = `SMIU_RST_WORD;
      end
      else
      begin
        st_next.tick_cnt = tick_inc;
      end
    end

    // Limit commands and flag clears
    if (wsel(`SMIU_A_CLK_CTRL))
    begin
      if (wdata[`SMIU_C_LIM_EN])
      begin
        st_next.lim_en = 1'b1;
      end
      if (wdata[`SMIU_C_LIM_DIS])
      begin
        st_next.lim_en = 1'b0;
      end
      st_next.every_tick = wdata[`SMIU_C_EVERY];
      if (wdata[`SMIU_C_CLR_LIM])
      begin
        st_next.lim_flag = 1'b0;
      end
      if (wdata[`SMIU_C_CLR_LOST])
      begin
        st_next.lost_cnt = 1'b0;
      end
    end

    // Pending clears are write-one-to-clear
    micro_clr = wsel(`SMIU_A_PEND_MICRO) ? wdata : `SMIU_RST_WORD;
    macro_clr = wsel(`SMIU_A_PEND_MACRO) ? wdata : `SMIU_RST_WORD;
    if (macro_clr[`SMIU_L_RTC])
    begin
      st_next.lim_flag = 1'b0;
    end

    // Limit event raises the flag or records a lost count
    if (lim_evt && st_reg.lim_en)
    begin
      if (st_reg.lim_flag)
      begin
        st_next.lost_cnt = 1'b1;
      end
      else
      begin
        st_next.lim_flag = 1'b1;
      end
    end

    // Memory parity checks
    word_bad = mem_chk && ((^mem_word[`SMIU_M_DPAR:0]) != `SMIU_PAR_ODD);
    prot_bad = mem_chk && prot_on
      && ((^mem_word[`SMIU_M_PPAR:`SMIU_M_PROT]) != `SMIU_PAR_ODD);
    if (wsel(`SMIU_A_PARITY) && wdata[`SMIU_P_ERR])
    begin
      st_next.par_err = 1'b0;
      st_next.par_word = 1'b0;
      st_next.par_prot = 1'b0;
    end
    if (word_bad || prot_bad)
    begin
      st_next.par_err = 1'b1;
    end
    if (word_bad)
    begin
      st_next.par_word = 1'b1;
    end
    if (prot_bad)
    begin
      st_next.par_prot = 1'b1;
    end

    // Request latching; a set wins over a clear in the same cycle
    micro_set = micro_lvl;
    micro_set[`SMIU_L_RTC] = micro_lvl[`SMIU_L_RTC] | tick;
    macro_set = macro_lvl;
    macro_set[`SMIU_L_RTC] = macro_lvl[`SMIU_L_RTC] | (lim_evt && st_reg.lim_en);
    macro_set[`SMIU_L_PARITY] = macro_lvl[`SMIU_L_PARITY] | word_bad | prot_bad;
    st_next.pend_micro = (st_reg.pend_micro & ~micro_clr) | micro_set;
    st_next.pend_macro = (st_reg.pend_macro & ~macro_clr) | macro_set;

    // Service selection: micro first, macro only when enabled
    if (mi_valid)
    begin
      st_next.serv_valid = 1'b1;
      st_next.serv_micro = 1'b1;
      st_next.serv_index = mi_index;
    end
    else if (ma_valid && st_reg.sm_macro[`SMIU_B_MACRO_EN])
    begin
      st_next.serv_valid = 1'b1;
      st_next.serv_micro = 1'b0;
      st_next.serv_index = ma_index;
    end
    else
    begin
      st_next.serv_valid = 1'b0;
      st_next.serv_micro = 1'b0;
      st_next.serv_index = '0;
    end

    // Read data stand one cycle after the strobe only
    st_next.rdata = `SMIU_RST_WORD;
    if (rd)
    begin
      unique case (addr)
        `SMIU_A_SM_MICRO: st_next.rdata = st_reg.sm_micro;
        `SMIU_A_SM_MACRO: st_next.rdata = st_reg.sm_macro;
        `SMIU_A_MASK_MICRO: st_next.rdata = st_reg.mask_micro;
        `SMIU_A_MASK_MACRO: st_next.rdata = st_reg.mask_macro;
        `SMIU_A_PEND_MICRO: st_next.rdata = st_reg.pend_micro;
        `SMIU_A_PEND_MACRO: st_next.rdata = st_reg.pend_macro;
        `SMIU_A_LIMIT: st_next.rdata = st_reg.limit_n;
        `SMIU_A_CLK_CTRL:
        begin
          st_next.rdata[`SMIU_C_LIM_EN] = st_reg.lim_en;
          st_next.rdata[`SMIU_C_EVERY] = st_reg.every_tick;
          st_next.rdata[`SMIU_S_LIM_FLAG] = st_reg.lim_flag;
          st_next.rdata[`SMIU_S_LOST] = st_reg.lost_cnt;
        end
        `SMIU_A_VECTOR:
          st_next.rdata = {mi_valid, ma_valid, 6'h00, ma_index, mi_index};
        `SMIU_A_PARITY:
        begin
          st_next.rdata[`SMIU_P_ERR] = st_reg.par_err;
          st_next.rdata[`SMIU_P_WORD] = st_reg.par_word;
          st_next.rdata[`SMIU_P_PROT] = st_reg.par_prot;
        end
        default: st_next.rdata = `SMIU_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg <= '0;
      st_reg.limit_n <= `SMIU_RST_LIMIT;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign rdata = st_reg.rdata;
  assign serv_valid = st_reg.serv_valid;
  assign serv_micro = st_reg.serv_micro;
  assign serv_index = st_reg.serv_index;
  assign twos_comp = st_reg.sm_micro[`SMIU_B_TWOS];
  assign macro_int_en = st_reg.sm_macro[`SMIU_B_MACRO_EN];
  assign io_timing = st_reg.sm_micro[`SMIU_IO_LSB +: `SMIU_IO_W];
  assign rtc_tick = st_reg.rtc_tick;
  assign limit_flag = st_reg.lim_flag;
  assign lost_count = st_reg.lost_cnt;
  assign parity_err = st_reg.par_err;

endmodule

/* testbench/smiu_asserts.sv */
// Purpose: Port-level checks of the status-mode interrupt unit
// Assumes: One clock domain, reset active low
// Notes: Bound to the top module below
`timescale 1ns/100ps
`include "smiu_consts.svh"

module smiu_asserts #(
  parameter int TICK_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [`SMIU_AW-1:0] addr,
  input wire logic [`SMIU_DW-1:0] wdata,
  input wire logic wr,
  input wire logic [`SMIU_DW-1:0] alu_result,
  input wire logic alu_ld_sm_micro,
  input wire logic mem_chk,
  input wire logic [`SMIU_MW-1:0] mem_word,
  input wire logic protect_sw,
  input wire logic serv_valid,
  input wire logic serv_micro,
  input wire logic twos_comp,
  input wire logic macro_int_en,
  input wire logic [`SMIU_IO_W-1:0] io_timing,
  input wire logic rtc_tick,
  input wire logic limit_flag,
  input wire logic lost_count,
  input wire logic parity_err
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_sm_write;
    wr && addr == `SMIU_A_SM_MICRO && !alu_ld_sm_micro;
  endsequence
  sequence s_bad_prot;
    mem_chk && (^mem_word[16:0]) && !(^mem_word[18:17]);
  endsequence

  chk_twos_write: assert property (s_sm_write |=> twos_comp == $past(wdata[0]))
    else $error("twos mode bit not loaded");
  chk_io_write: assert property (s_sm_write |=> io_timing == $past(wdata[15:8]))
    else $error("io timing bits not loaded");
  chk_alu_load: assert property (alu_ld_sm_micro |=> twos_comp == $past(alu_result[0])
    && io_timing == $past(alu_result[15:8]))
    else $error("status mode not loaded from alu");
  chk_macro_gate: assert property (serv_valid && !serv_micro |-> $past(macro_int_en))
    else $error("macro served while disabled");
  chk_tick_period: assert property (rtc_tick |-> ##TICK_CYCLES rtc_tick)
    else $error("clock tick period wrong");
  chk_word_parity: assert property (mem_chk && !(^mem_word[16:0]) |=> parity_err)
    else $error("word parity error missed");
  chk_prot_off: assert property ((!protect_sw)[*6] ##0 s_bad_prot ##0 !parity_err
    |=> !parity_err)
    else $error("protect parity checked while off");
  chk_prot_on: assert property (protect_sw[*6] ##0 s_bad_prot |=> parity_err)
    else $error("protect parity error missed");
  chk_limit_tick: assert property ($rose(limit_flag) |-> rtc_tick || $past(rtc_tick))
    else $error("limit flag without tick");
  chk_lost_cause: assert property ($rose(lost_count) |-> $past(limit_flag))
    else $error("lost count without pending limit");
endmodule

bind smiu_top smiu_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .alu_result(alu_result),
  .alu_ld_sm_micro(alu_ld_sm_micro), .mem_chk(mem_chk), .mem_word(mem_word),
  .protect_sw(protect_sw), .serv_valid(serv_valid), .serv_micro(serv_micro),
  .twos_comp(twos_comp), .macro_int_en(macro_int_en), .io_timing(io_timing),
  .rtc_tick(rtc_tick), .limit_flag(limit_flag), .lost_count(lost_count),
  .parity_err(parity_err)
);

/* testbench/smiu_periph.sv */
// Purpose: Peripheral controllers raising request lines
// Assumes: Requests are levels held until dropped
// Notes: Raise and drop commands come from the bench
`timescale 1ns/100ps

module smiu_periph (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] set_micro,
  input wire logic [15:0] set_macro,
  input wire logic drop,
  output logic [15:0] micro_req,
  output logic [15:0] macro_req
);
  // One level per line, sixteen lines per group
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      micro_req <= 16'h0000;
      macro_req <= 16'h0000;
    end
    else
    begin
      micro_req <= drop ? 16'h0000 : (micro_req | set_micro);
      macro_req <= drop ? 16'h0000 : (macro_req | set_macro);
    end
  end
endmodule

/* testbench/smiu_top_tb.sv */
// Purpose: Self-checking bench of the status-mode interrupt unit
// Assumes: Clock tick shortened to 20 cycles
// Notes: Reads are noted in a queue and checked by a monitor
`timescale 1ns/100ps
`include "smiu_consts.svh"

module smiu_top_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, alu_result = 16'h0000, rdata, set_micro = 16'h0000;
  logic [15:0] set_macro = 16'h0000, micro_req, macro_req, r, m, k, v;
  logic wr = 1'b0, rd = 1'b0, rd_d = 1'b0, drop = 1'b0, mem_chk = 1'b0, protect_sw = 1'b0;
  logic ld_a = 1'b0, ld_b = 1'b0, ld_c = 1'b0, ld_d = 1'b0;
  logic [18:0] mem_word = 19'h0_0000;
  logic serv_valid, serv_micro, twos_comp, macro_int_en, rtc_tick;
  logic limit_flag, lost_count, parity_err;
  logic [3:0] serv_index;
  logic [7:0] io_timing;
  logic [4:0] e, mv;
  logic [31:0] seed = 32'hef42;
  logic [15:0] exp_q[$];
  int fails = 0, cmp_count = 0;

  smiu_periph i_per (.clk(clk), .rstn(rstn), .set_micro(set_micro), .set_macro(set_macro),
    .drop(drop), .micro_req(micro_req), .macro_req(macro_req));
  smiu_top #(.TICK_CYCLES(20)) i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .micro_req(micro_req), .macro_req(macro_req),
    .protect_sw(protect_sw), .alu_result(alu_result), .alu_ld_sm_micro(ld_a),
    .alu_ld_sm_macro(ld_b), .alu_ld_mask_micro(ld_c), .alu_ld_mask_macro(ld_d),
    .mem_chk(mem_chk), .mem_word(mem_word), .serv_valid(serv_valid), .serv_micro(serv_micro),
    .serv_index(serv_index), .twos_comp(twos_comp), .macro_int_en(macro_int_en),
    .io_timing(io_timing), .rtc_tick(rtc_tick), .limit_flag(limit_flag),
    .lost_count(lost_count), .parity_err(parity_err));

  always #5 clk = ~clk;

  task end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic void rnd(output logic [15:0] o);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    o = seed[15:0];
  endfunction

  function automatic logic [4:0] low(input logic [15:0] x);
    low = 5'h00;
    for (int i = 15; i >= 0; i--)
      if (x[i])
        low = {1'b1, i[3:0]};
  endfunction

  task wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rd_reg(input logic [3:0] a, input logic [15:0] x);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(x);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task mem(input logic [18:0] w);
    @(posedge clk);
    mem_chk <= 1'b1;
    mem_word <= w;
    @(posedge clk);
    mem_chk <= 1'b0;
  endtask

  task tick_wait(input int n);
    repeat (n) @(posedge clk iff rtc_tick === 1'b1);
    repeat (2) @(posedge clk);
  endtask

  task serv_chk(input logic [5:0] x);
    repeat (2) @(posedge clk);
    check({10'h000, serv_valid, serv_micro, serv_index}, {10'h000, x});
  endtask

  // Read data appear in the cycle after the read strobe
  always @(posedge clk)
  begin
    rd_d <= rd;
    if (rd_d === 1'b1)
      check(rdata, exp_q.pop_front());
  end

  initial
  begin
    #400000;
    fails++;
    end_of_test();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a < 11; a++)
      rd_reg(a[3:0], (a == 6) ? 16'h0001 : 16'h0000);
    check({15'h0000, twos_comp}, 16'h0000);
    foreach (exp_q[i]) @(posedge clk);
    for (int a = 0; a < 7; a++)
    begin
      rnd(v);
      wr_reg((a == 4) ? 4'h6 : ((a == 5) ? 4'hc : a[3:0]), v);
      rd_reg((a == 4) ? 4'h6 : ((a == 5) ? 4'hc : a[3:0]), (a == 5) ? 16'h0000 : v);
    end
    for (int a = 0; a < 4; a++)
    begin
      rnd(v);
      @(posedge clk);
      alu_result <= v;
      {ld_d, ld_c, ld_b, ld_a} <= 4'h1 << a;
      @(posedge clk);
      {ld_d, ld_c, ld_b, ld_a} <= 4'h0;
      rd_reg(a[3:0], v);
      wr_reg(a[3:0], 16'h0000);
    end
    $display("test registers done");
    rnd(r);
    rnd(m);
    r = (r & 16'hfeff) | 16'h8000;
    m = (m & 16'hfefe) | 16'h8000;
    set_micro <= r;
    set_macro <= m;
    @(posedge clk);
    set_micro <= 16'h0000;
    set_macro <= 16'h0000;
    repeat (6) @(posedge clk);
    drop <= 1'b1;
    @(posedge clk);
    drop <= 1'b0;
    wr_reg(4'h1, 16'h0001);
    wr_reg(4'h3, 16'hffff);
    mv = low(m);
    serv_chk({2'b10, mv[3:0]});
    for (int i = 0; i < 4; i++)
    begin
      rnd(k);
      k = k & 16'hfeff;
      wr_reg(4'h2, k);
      e = low(r & k);
      serv_chk(e[4] ? {2'b11, e[3:0]} : {2'b10, mv[3:0]});
      rd_reg(4'h8, {e[4], mv[4], 6'h00, mv[3:0], e[3:0]});
    end
    wr_reg(4'h2, 16'h0000);
    wr_reg(4'h1, 16'h0000);
    serv_chk(6'h00);
    rd_reg(4'h5, m);
    wr_reg(4'h5, 16'hffff);
    rd_reg(4'h5, 16'h0000);
    $display("test priority done");
    wr_reg(4'h2, 16'h0100);
    tick_wait(1);
    wr_reg(4'h4, 16'h0100);
    rd_reg(4'h4, r);
    serv_chk(6'h00);
    tick_wait(1);
    check({10'h000, serv_valid, serv_micro, serv_index}, 16'h0038);
    wr_reg(4'h2, 16'h0000);
    wr_reg(4'h6, 16'h0003);
    wr_reg(4'h7, 16'h0019);
    wr_reg(4'h3, 16'h0100);
    wr_reg(4'h1, 16'h0001);
    @(posedge clk iff limit_flag === 1'b1);
    serv_chk(6'h28);
    wr_reg(4'h7, 16'h0008);
    tick_wait(2);
    check({15'h0000, limit_flag}, 16'h0000);
    tick_wait(1);
    check({15'h0000, limit_flag}, 16'h0001);
    tick_wait(3);
    check({15'h0000, lost_count}, 16'h0001);
    rd_reg(4'h7, 16'h0061);
    wr_reg(4'h7, 16'h001d);
    tick_wait(1);
    check({15'h0000, limit_flag}, 16'h0001);
    wr_reg(4'h5, 16'h0100);
    rd_reg(4'h7, 16'h0005);
    wr_reg(4'h7, 16'h000b);
    tick_wait(4);
    check({15'h0000, limit_flag}, 16'h0000);
    rd_reg(4'h7, 16'h0000);
    wr_reg(4'h1, 16'h0000);
    $display("test clock done");
    rnd(v);
    mem({1'b1, 1'b0, ~^v, v});
    mem({1'b0, 1'b0, ~^v, v});
    rd_reg(4'h9, 16'h0000);
    mem({1'b1, 1'b0, ^v, v});
    rd_reg(4'h9, 16'h0003);
    wr_reg(4'h9, 16'h0001);
    rd_reg(4'h9, 16'h0000);
    protect_sw <= 1'b1;
    repeat (8) @(posedge clk);
    mem({1'b0, 1'b0, ~^v, v});
    rd_reg(4'h9, 16'h0005);
    repeat (4) @(posedge clk);
    $display("test parity done");
    end_of_test();
  end
endmodule
